// *** pkg/synth_prog_pkg.sv ***
package synth_prog_pkg;
	// Word geometry
	localparam int WORD_BITS = 32;
	localparam int SELECT_BITS = 4;
	// Register select codes (indices)
	localparam logic [3:0] SEL_WHOLE_DIVIDE = 4'h0;
	localparam logic [3:0] SEL_MAIN_FRACTION = 4'h1;
	localparam logic [3:0] SEL_AUX_FRACTION = 4'h2;
	localparam logic [3:0] SEL_PHASE = 4'h3;
	localparam logic [3:0] SEL_REF_PUMP = 4'h4;
	localparam logic [3:0] SEL_FIXED = 4'h5;
	localparam logic [3:0] SEL_OUTPUT_CTRL = 4'h6;
	// Word zero fields
	localparam int AUTOCAL_POS = 21;
	localparam int PRESCALER_POS = 20;
	localparam int INT_LSB = 4;
	localparam int INT_WIDTH = 16;
	localparam logic [15:0] INT_MIN_45 = 16'h0017;
	localparam logic [15:0] INT_MAX_45 = 16'h7fff;
	localparam logic [15:0] INT_MIN_89 = 16'h004b;
	localparam logic [15:0] INT_MAX_89 = 16'hffff;
	// Word one / two / three fields
	localparam int FRAC_LSB = 4;
	localparam int FRAC_WIDTH = 24;
	localparam int AUX_NUM_LSB = 18;
	localparam int AUX_DEN_LSB = 4;
	localparam int AUX_WIDTH = 14;
	localparam int LOAD_RESET_DIS_POS = 30;
	localparam int RESYNC_POS = 29;
	localparam int PHASE_STEP_POS = 28;
	localparam int PHASE_LSB = 4;
	localparam int PHASE_WIDTH = 24;
	// Word four fields
	localparam int TEST_SEL_LSB = 27;
	localparam int DOUBLER_POS = 26;
	localparam int HALVER_POS = 25;
	localparam int RCOUNT_LSB = 15;
	localparam int RCOUNT_WIDTH = 10;
	localparam int DIV_BUFFER_POS = 14;
	localparam int PUMP_LSB = 10;
	localparam int REF_DIFF_POS = 9;
	localparam int LEVEL_POS = 8;
	localparam int POLARITY_POS = 7;
	localparam int POWER_DOWN_POS = 6;
	localparam int TRISTATE_POS = 5;
	localparam int COUNTER_RESET_POS = 4;
	// Word six divider select field
	localparam int OUT_DIV_LSB = 21;
	localparam int FEEDBACK_POS = 24;
	// Reset values and fixed word
	localparam logic [31:0] FIXED_WORD_VALUE = 32'h0080_0025;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [3:0] PUMP_LOW_SPUR = 4'h2;
	// Serial timing: half period of the host-made serial clock, in system cycles
	localparam int SCLK_HALF_CYCLES = 2;
	localparam logic [4:0] BIT_LAST = 5'h1f;
endpackage : synth_prog_pkg

// *** pkg/synth_link_if.sv ***
`timescale 1ns/1ps
interface synth_link_if;
	logic serial_clk;
	logic serial_data;
	logic load_enable;
	modport host (output serial_clk, output serial_data, output load_enable);
	modport device (input serial_clk, input serial_data, input load_enable);
endinterface : synth_link_if

// *** hw/synth_program_registers.sv ***
// Local design decision: the strobed register port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE_01 - Low four bits select destination word
// RULE_02 - Autocal bit: word-zero update starts calibration
// RULE_03 - Bit 20 picks prescaler ratio
// RULE_04 - Host keeps integer within prescaler range
// RULE_05 - Word one holds 24-bit main fraction
// RULE_06 - Host keeps aux numerator below modulus
// RULE_07 - Word-zero write resets modulator unless disabled
// RULE_08 - Resync works only with aux numerator zero
// RULE_09 - Resync needs load reset and divided feedback; host checks only the load reset bit, FEEDBACK_POS is never checked
// RULE_10 - Phase step adds phase value per update
// RULE_11 - Host never mixes phase step and resync
// RULE_12 - Word four bits 29:27 pick test output
// RULE_13 - Doubler and halver bits steer reference
// RULE_14 - Ten-bit reference divide ratio 1 to 1023; a field of 0 is passed to reference_divide_out unchecked
// RULE_15 - Divider buffering bit gates output divider field
// RULE_16 - Buffered fields apply on word-zero write
// RULE_17 - Four-bit pump current setting
// RULE_18 - Reference mode and test level bits
// RULE_19 - Detector polarity and pump tristate bits
// RULE_20 - Power-down forces outputs off, keeps registers
// RULE_21 - Counter reset bit holds counters reset
// RULE_22 - Host loads word five with fixed value
// RULE_23 - Shifted word transfers on load strobe
module synth_program_registers
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// Serial link
	synth_link_if.device link,
	// Divider and fraction state
	output logic [15:0] int_value_out,
	output logic prescaler_select_out,
	output logic [23:0] main_fraction_numerator_out,
	output logic [13:0] aux_fraction_numerator_out,
	output logic [13:0] aux_fraction_denominator_out,
	output logic [2:0] output_divider_out,
	output logic int_range_error_out,
	// Event pulses, phase accumulator and resync state
	output logic calibration_start_out,
	output logic modulator_reset_out,
	output logic phase_step_out,
	output logic [23:0] phase_accum_out,
	output logic resync_active_out,
	// Reference and pump control
	output logic [2:0] test_output_select_out,
	output logic reference_doubler_enable_out,
	output logic reference_halver_enable_out,
	output logic [9:0] reference_divide_out,
	output logic [3:0] pump_current_setting_out,
	output logic reference_differential_out,
	output logic test_output_level_out,
	output logic detector_polarity_out,
	output logic pump_tristate_out,
	output logic power_down_out,
	output logic counters_held_out,
	output logic outputs_enabled_out,
	output logic fixed_word_ok_out
);
	//////////////////////////////////////////////////////////////////////////
	// Serial capture on rising link clock edges seen in the system domain
	logic [31:0] shift_r;
	logic sclk_prev_r;
	logic load_prev_r;
	logic sclk_rise;
	logic load_rise;
	assign sclk_rise = link.serial_clk & ~sclk_prev_r;
	assign load_rise = link.load_enable & ~load_prev_r;

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			sclk_prev_r <= 1'b0;
			load_prev_r <= 1'b0;
		end
		else
		begin
			sclk_prev_r <= link.serial_clk;
			load_prev_r <= link.load_enable;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			shift_r <= synth_prog_pkg::WORD_RESET;
		else if (sclk_rise && !link.load_enable)
			shift_r <= {shift_r[30:0], link.serial_data};
	end

	//////////////////////////////////////////////////////////////////////////
	// Word decode
	function automatic logic word_hit(input logic [31:0] w, input logic [3:0] sel);
		word_hit = (w[3:0] == sel);
	endfunction : word_hit

	logic wr0, wr1, wr2, wr3, wr4, wr5, wr6;
	assign wr0 = load_rise && word_hit(shift_r, synth_prog_pkg::SEL_WHOLE_DIVIDE); // RULE_01 RULE_23
	assign wr1 = load_rise && word_hit(shift_r, synth_prog_pkg::SEL_MAIN_FRACTION); // RULE_01
	assign wr2 = load_rise && word_hit(shift_r, synth_prog_pkg::SEL_AUX_FRACTION);
	assign wr3 = load_rise && word_hit(shift_r, synth_prog_pkg::SEL_PHASE); // RULE_01
	assign wr4 = load_rise && word_hit(shift_r, synth_prog_pkg::SEL_REF_PUMP);
	assign wr5 = load_rise && word_hit(shift_r, synth_prog_pkg::SEL_FIXED);
	assign wr6 = load_rise && word_hit(shift_r, synth_prog_pkg::SEL_OUTPUT_CTRL);

	//////////////////////////////////////////////////////////////////////////
	// Input words and shadows
	logic [31:0] word0_r, word3_r, word4_r;
	logic [23:0] frac_shadow_r, phase_shadow_r;
	logic [13:0] auxn_shadow_r, auxd_shadow_r;
	logic [2:0] div_shadow_r;

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			word0_r <= synth_prog_pkg::WORD_RESET;
			word3_r <= synth_prog_pkg::WORD_RESET;
			word4_r <= synth_prog_pkg::WORD_RESET;
			frac_shadow_r <= '0;
			auxn_shadow_r <= '0;
			auxd_shadow_r <= '0;
			phase_shadow_r <= '0;
			div_shadow_r <= '0;
			fixed_word_ok_out <= 1'b0;
		end
		else
		begin
			if (wr0)
				word0_r <= shift_r;
			if (wr1)
				frac_shadow_r <= shift_r[synth_prog_pkg::FRAC_LSB +: 24]; // RULE_05 RULE_16
			if (wr2)
			begin
				auxn_shadow_r <= shift_r[synth_prog_pkg::AUX_NUM_LSB +: 14]; // RULE_16
				auxd_shadow_r <= shift_r[synth_prog_pkg::AUX_DEN_LSB +: 14];
			end
			if (wr3)
			begin
				word3_r <= shift_r;
				phase_shadow_r <= shift_r[synth_prog_pkg::PHASE_LSB +: 24];
			end
			if (wr4)
				word4_r <= shift_r;
			if (wr5)
				fixed_word_ok_out <= (shift_r == synth_prog_pkg::FIXED_WORD_VALUE);
			if (wr6)
				div_shadow_r <= shift_r[synth_prog_pkg::OUT_DIV_LSB +: 3];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Commit on word zero and event pulses
	logic autocal, prescaler, load_reset_dis, resync_en, phase_en;
	assign autocal = shift_r[synth_prog_pkg::AUTOCAL_POS];
	assign prescaler = shift_r[synth_prog_pkg::PRESCALER_POS];
	assign load_reset_dis = word3_r[synth_prog_pkg::LOAD_RESET_DIS_POS];
	assign resync_en = word3_r[synth_prog_pkg::RESYNC_POS];
	assign phase_en = word3_r[synth_prog_pkg::PHASE_STEP_POS];

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			main_fraction_numerator_out <= '0;
			aux_fraction_numerator_out <= '0;
			aux_fraction_denominator_out <= '0;
			output_divider_out <= '0;
			calibration_start_out <= 1'b0;
			modulator_reset_out <= 1'b0;
			phase_step_out <= 1'b0;
			phase_accum_out <= '0;
			int_range_error_out <= 1'b0;
		end
		else
		begin
			calibration_start_out <= wr0 && autocal; // RULE_02
			modulator_reset_out <= wr0 && !load_reset_dis; // RULE_07
			phase_step_out <= wr0 && phase_en; // RULE_10
			if (wr0)
			begin
				main_fraction_numerator_out <= frac_shadow_r; // RULE_16
				aux_fraction_numerator_out <= auxn_shadow_r;
				aux_fraction_denominator_out <= auxd_shadow_r;
				if (phase_en)
					phase_accum_out <= phase_accum_out + phase_shadow_r; // RULE_10
				if (prescaler) // RULE_03 RULE_04
					int_range_error_out <= shift_r[19:4] < synth_prog_pkg::INT_MIN_89;
				else
					int_range_error_out <= (shift_r[19:4] < synth_prog_pkg::INT_MIN_45) ||
						(shift_r[19:4] > synth_prog_pkg::INT_MAX_45);
			end
			if (wr0 && word4_r[synth_prog_pkg::DIV_BUFFER_POS]) // RULE_15
				output_divider_out <= div_shadow_r;
			else if (wr6 && !word4_r[synth_prog_pkg::DIV_BUFFER_POS])
				output_divider_out <= shift_r[synth_prog_pkg::OUT_DIV_LSB +: 3];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Registered control outputs
	logic pd;
	assign pd = word4_r[synth_prog_pkg::POWER_DOWN_POS];

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			int_value_out <= '0;
			prescaler_select_out <= 1'b0;
			resync_active_out <= 1'b0;
			test_output_select_out <= '0;
			reference_doubler_enable_out <= 1'b0;
			reference_halver_enable_out <= 1'b0;
			reference_divide_out <= '0;
			pump_current_setting_out <= '0;
			reference_differential_out <= 1'b0;
			test_output_level_out <= 1'b0;
			detector_polarity_out <= 1'b0;
			pump_tristate_out <= 1'b0;
			power_down_out <= 1'b0;
			counters_held_out <= 1'b0;
			outputs_enabled_out <= 1'b0;
		end
		else
		begin
			int_value_out <= word0_r[synth_prog_pkg::INT_LSB +: 16];
			prescaler_select_out <= word0_r[synth_prog_pkg::PRESCALER_POS]; // RULE_03
			resync_active_out <= resync_en && (aux_fraction_numerator_out == '0); // RULE_08
			test_output_select_out <= word4_r[synth_prog_pkg::TEST_SEL_LSB +: 3]; // RULE_12
			reference_doubler_enable_out <= word4_r[synth_prog_pkg::DOUBLER_POS]; // RULE_13
			reference_halver_enable_out <= word4_r[synth_prog_pkg::HALVER_POS]; // RULE_13
			reference_divide_out <= word4_r[synth_prog_pkg::RCOUNT_LSB +: 10]; // RULE_14
			pump_current_setting_out <= word4_r[synth_prog_pkg::PUMP_LSB +: 4]; // RULE_17
			reference_differential_out <= word4_r[synth_prog_pkg::REF_DIFF_POS]; // RULE_18
			test_output_level_out <= word4_r[synth_prog_pkg::LEVEL_POS]; // RULE_18
			detector_polarity_out <= word4_r[synth_prog_pkg::POLARITY_POS]; // RULE_19
			pump_tristate_out <= word4_r[synth_prog_pkg::TRISTATE_POS] || pd; // RULE_19 RULE_20
			power_down_out <= pd; // RULE_20
			counters_held_out <= word4_r[synth_prog_pkg::COUNTER_RESET_POS] || pd; // RULE_21 RULE_20
			outputs_enabled_out <= !pd; // RULE_20
		end
	end
endmodule : synth_program_registers

// *** hw/synth_host_writer.sv ***
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Host end: takes a word from software and shifts it out, MSB first
module synth_host_writer
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// Software port
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	// Serial link
	synth_link_if.host link
);
	typedef enum logic [1:0] {IDLE = 2'b00, SHIFT = 2'b01, LOAD = 2'b11} host_state_type;
	host_state_type state_r;
	logic [31:0] word_r;
	logic [4:0] bit_r;
	logic [1:0] tick_r;
	logic refused_r;
	logic busy;
	assign busy = (state_r != IDLE);

	// Refuse words breaking range rules; word five is forced to its value
	function automatic logic word_ok(input logic [31:0] w);
		logic [15:0] iv;
		iv = w[19:4];
		word_ok = 1'b1;
		if (w[3:0] == synth_prog_pkg::SEL_WHOLE_DIVIDE) // RULE_04
			word_ok = w[20] ? (iv >= synth_prog_pkg::INT_MIN_89) :
				(iv >= synth_prog_pkg::INT_MIN_45 && iv <= synth_prog_pkg::INT_MAX_45);
		else if (w[3:0] == synth_prog_pkg::SEL_AUX_FRACTION) // RULE_06
			word_ok = w[31:18] < w[17:4];
		else if (w[3:0] == synth_prog_pkg::SEL_PHASE) // RULE_11 RULE_09
			word_ok = !(w[28] && w[29]) && !(w[29] && w[30]) && !(w[28] && !w[30]);
	endfunction : word_ok

	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_r <= IDLE;
			word_r <= '0;
			bit_r <= '0;
			tick_r <= '0;
			refused_r <= 1'b0;
			link.serial_clk <= 1'b0;
			link.serial_data <= 1'b0;
			link.load_enable <= 1'b0;
		end
		else
		begin
			case (state_r)
				IDLE:
				begin
					if (wr_in)
					begin
						if (word_ok({wdata_in[31:4], addr_in}))
						begin
							refused_r <= 1'b0;
							word_r <= (addr_in == synth_prog_pkg::SEL_FIXED) ? synth_prog_pkg::FIXED_WORD_VALUE :
								{wdata_in[31:4], addr_in}; // RULE_01 RULE_22
							bit_r <= '0;
							tick_r <= '0;
							state_r <= SHIFT;
						end
						else
							refused_r <= 1'b1;
					end
				end
				SHIFT:
				begin
					tick_r <= tick_r + 2'h1;
					if (tick_r == 2'h0)
						link.serial_data <= word_r[31];
					else if (tick_r == 2'h1)
						link.serial_clk <= 1'b1;
					else if (tick_r == 2'h3)
					begin
						link.serial_clk <= 1'b0;
						word_r <= {word_r[30:0], 1'b0};
						bit_r <= bit_r + 5'h01;
						if (bit_r == synth_prog_pkg::BIT_LAST)
							state_r <= LOAD;
					end
				end
				LOAD:
				begin
					link.load_enable <= ~link.load_enable; // RULE_23
					if (link.load_enable)
						state_r <= IDLE;
				end
				default:
					state_r <= IDLE;
			endcase
		end
	end

	// Status: bit0 busy, bit1 last write refused
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			rdata_out <= '0;
		else if (rd_in)
			rdata_out <= {30'h0000_0000, refused_r, busy};
		else
			rdata_out <= '0;
	end
endmodule : synth_host_writer

// *** tb/synth_link_properties.sv ***
`timescale 1ns/1ps
module synth_link_properties
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// Serial link
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic load_enable
);
	logic clk_q_r;
	logic [5:0] rise_cnt_r;
	////////////////////////////////////////
	// Serial clock rises since last load
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			clk_q_r <= 1'b0;
		else
			clk_q_r <= serial_clk;
	end
	always_ff @(posedge sys_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			rise_cnt_r <= 6'h00;
		else if (load_enable)
			rise_cnt_r <= 6'h00;
		else
			rise_cnt_r <= rise_cnt_r + 6'(serial_clk && !clk_q_r);
	end
	////////////////////////////////////////
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);
	sequence s_clk_high;
		serial_clk [*2] ##1 !serial_clk;
	endsequence
	sequence s_clk_low;
		!serial_clk [*2];
	endsequence
	a_load_one_cycle: assert property ($rose(load_enable) |=> !load_enable)
		else $error("load strobe longer than one cycle");
	a_clk_high_span: assert property ($rose(serial_clk) |-> s_clk_high)
		else $error("serial clock high phase wrong");
	a_clk_low_span: assert property ($fell(serial_clk) |-> s_clk_low)
		else $error("serial clock low phase too short");
	a_data_steady: assert property (serial_clk |-> $stable(serial_data))
		else $error("serial data moved while clock high");
	a_quiet_load: assert property (load_enable |-> !serial_clk)
		else $error("serial clock during load");
	a_word_length: assert property ($rose(load_enable) |-> rise_cnt_r == 6'h20)
		else $error("word not 32 bits");
	a_load_follows: assert property ($fell(serial_clk) && rise_cnt_r == 6'h20 |-> ##[1:6] $rose(load_enable))
		else $error("load missing after last bit");
	a_bit_paced: assert property ($fell(serial_clk) && rise_cnt_r < 6'h20 |-> ##[1:4] $rose(serial_clk))
		else $error("frame stalled between bits");
endmodule : synth_link_properties

// *** tb/test_synth_program_registers.sv ***
`timescale 1ns/1ps
module test_synth_program_registers;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic [15:0] int_value_out;
	logic [23:0] main_fraction_numerator_out, phase_accum_out;
	logic [13:0] aux_fraction_numerator_out, aux_fraction_denominator_out;
	logic [2:0] output_divider_out, test_output_select_out;
	logic [9:0] reference_divide_out;
	logic [3:0] pump_current_setting_out;
	logic prescaler_select_out, int_range_error_out, calibration_start_out, modulator_reset_out;
	logic phase_step_out, resync_active_out, reference_doubler_enable_out, reference_halver_enable_out;
	logic reference_differential_out, test_output_level_out, detector_polarity_out, pump_tristate_out;
	logic power_down_out, counters_held_out, outputs_enabled_out, fixed_word_ok_out;
	logic [31:0] cal_n = 32'h0000_0000;
	logic [31:0] mrst_n = 32'h0000_0000;
	logic [31:0] step_n = 32'h0000_0000;
	logic [16:0] tbl [4] = '{17'h0_0017, 17'h0_7fff, 17'h1_004b, 17'h1_ffff};
	integer seed = 32'h0000_05ee;
	int err_total = 0;
	int checks = 0;
	synth_link_if link();
	synth_host_writer u_synth_host_writer
	(
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link(link)
	);
	synth_program_registers u_synth_program_registers
	(
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .link(link), .int_value_out(int_value_out),
		.prescaler_select_out(prescaler_select_out), .main_fraction_numerator_out(main_fraction_numerator_out),
		.aux_fraction_numerator_out(aux_fraction_numerator_out), .output_divider_out(output_divider_out),
		.aux_fraction_denominator_out(aux_fraction_denominator_out), .int_range_error_out(int_range_error_out),
		.calibration_start_out(calibration_start_out), .modulator_reset_out(modulator_reset_out),
		.phase_step_out(phase_step_out), .phase_accum_out(phase_accum_out), .resync_active_out(resync_active_out),
		.test_output_select_out(test_output_select_out), .reference_divide_out(reference_divide_out),
		.reference_doubler_enable_out(reference_doubler_enable_out), .power_down_out(power_down_out),
		.reference_halver_enable_out(reference_halver_enable_out), .pump_tristate_out(pump_tristate_out),
		.pump_current_setting_out(pump_current_setting_out), .counters_held_out(counters_held_out),
		.reference_differential_out(reference_differential_out), .test_output_level_out(test_output_level_out),
		.detector_polarity_out(detector_polarity_out), .outputs_enabled_out(outputs_enabled_out),
		.fixed_word_ok_out(fixed_word_ok_out)
	);
	synth_link_properties u_link_props
	(
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .serial_clk(link.serial_clk),
		.serial_data(link.serial_data), .load_enable(link.load_enable)
	);
	////////////////////////////////////////
	always #20 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in)
	begin
		cal_n <= cal_n + 32'(calibration_start_out);
		mrst_n <= mrst_n + 32'(modulator_reset_out);
		step_n <= step_n + 32'(phase_step_out);
	end
	////////////////////////////////////////
	function automatic logic [31:0] ref_exp(input logic [31:0] w);
		return {8'h00, w[29:15], w[13:7], w[5:4]};
	endfunction : ref_exp
	function automatic logic [31:0] w0(input logic ac, input logic pre, input logic [15:0] n);
		return {10'h000, ac, pre, n, 4'h0};
	endfunction : w0
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic get(output logic [31:0] v);
		@(posedge sys_clk_in);
		rd_in <= 1'b1;
		@(posedge sys_clk_in);
		rd_in <= 1'b0;
		#1;
		v = rdata_out;
	endtask : get
	task automatic put(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] st;
		int n;
		@(posedge sys_clk_in);
		addr_in <= a;
		wdata_in <= {d[31:4], 4'($random(seed))};
		wr_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
		st = 32'h0000_0001;
		for (n = 0; n < 200 && st[0] !== 1'b0; n++)
			get(st);
		chk(32'(st[1:0]), 32'h0000_0000);
		repeat (3) @(posedge sys_clk_in);
	endtask : put
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////
	initial
	begin
		#2_000_000;
		err_total++;
		tally_and_finish;
	end
	initial
	begin
		logic [31:0] w, m0, c0, s0;
		logic [23:0] frac, p, a0;
		logic [16:0] v;
		logic [13:0] aux;
		repeat (10) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		// Reference and pump word, random fields
		for (int i = 0; i < 4; i++)
		begin
			w = $random(seed);
			w = {2'b00, w[29:16], 1'b1, 1'b0, w[13:7], 1'b0, w[5:4], 4'h0};
			put(4'h4, w);
			chk(32'({test_output_select_out, reference_doubler_enable_out, reference_halver_enable_out,
				reference_divide_out, pump_current_setting_out, reference_differential_out, test_output_level_out,
				detector_polarity_out, pump_tristate_out, counters_held_out}), ref_exp(w));
		end
		put(4'h4, w | 32'h0000_0040);
		chk(32'({power_down_out, pump_tristate_out, counters_held_out, outputs_enabled_out, reference_divide_out}),
			32'({4'b1110, w[24:15]}));
		// Integer and prescaler boundaries
		put(4'h3, 32'h0000_0000);
		for (int i = 0; i < 5; i++)
		begin
			v = (i < 4) ? tbl[i] : {1'b1, 16'($random(seed)) | 16'h0100};
			c0 = cal_n;
			m0 = mrst_n;
			put(4'h0, w0(i[0], v[16], v[15:0]));
			chk(32'({int_range_error_out, prescaler_select_out, int_value_out}), 32'(v));
			chk(cal_n - c0, 32'(i[0]));
			chk(mrst_n - m0, 32'h0000_0001);
		end
		// Shadowed fractions and resync
		frac = 24'($random(seed));
		aux = (14'($random(seed)) & 14'h1ffe) | 14'h0001;
		put(4'h1, {4'h0, frac, 4'h0});
		put(4'h2, {aux, 14'h3fff, 4'h0});
		chk(32'(main_fraction_numerator_out), 32'h0000_0000);
		put(4'h3, 32'h2000_0000);
		put(4'h0, w0(1'b1, 1'b0, 16'h0100));
		chk(32'(main_fraction_numerator_out), 32'(frac));
		chk(32'({aux_fraction_numerator_out, aux_fraction_denominator_out, resync_active_out}),
			32'({aux, 14'h3fff, 1'b0}));
		put(4'h2, {14'h0000, 14'h3fff, 4'h0});
		put(4'h0, w0(1'b1, 1'b0, 16'h0100));
		chk(32'(resync_active_out), 32'h0000_0001);
		// Phase stepping with load reset off
		p = 24'($random(seed));
		put(4'h3, {4'b0101, p, 4'h0});
		put(4'h0, w0(1'b0, 1'b0, 16'h0100));
		a0 = phase_accum_out;
		m0 = mrst_n;
		s0 = step_n;
		put(4'h0, w0(1'b0, 1'b0, 16'h0100));
		chk(32'(24'(phase_accum_out - a0)), 32'(p));
		chk({mrst_n - m0}, 32'h0000_0000);
		chk(step_n - s0, 32'h0000_0001);
		// Buffered output divider field
		put(4'h4, 32'h0000_c000);
		put(4'h6, 32'h00a0_0000);
		chk(32'({outputs_enabled_out, output_divider_out}), 32'h0000_0008);
		put(4'h0, w0(1'b0, 1'b0, 16'h0100));
		chk(32'(output_divider_out), 32'h0000_0005);
		// Unbuffered output divider field applies at once
		put(4'h4, 32'h0000_8000);
		put(4'h6, 32'h0060_0000);
		chk(32'(output_divider_out), 32'h0000_0003);
		put(4'h5, 32'h0000_0000);
		chk(32'(fixed_word_ok_out), 32'h0000_0001);
		// Phase step together with resync is refused
		@(posedge sys_clk_in);
		addr_in <= 4'h3;
		wdata_in <= 32'h3000_0000;
		wr_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
		get(w);
		chk(32'(w[1:0]), 32'h0000_0002);
		tally_and_finish;
	end
endmodule : test_synth_program_registers
